// [shared/identify_param_map.svh]
// Constants for the identify parameter record: word indices, field bits,
// defaults and the register port map. Included by the package and design.
`ifndef IDENTIFY_PARAM_MAP_SVH
`define IDENTIFY_PARAM_MAP_SVH

`define IDP_WORDS 256
`define IDP_W_CONFIG 8'h00
`define IDP_W_CYL 8'h01
`define IDP_W_HEAD 8'h03
`define IDP_W_SPT 8'h06
`define IDP_W_TOT_LO 8'h07
`define IDP_W_TOT_HI 8'h08
`define IDP_W_SER_FIRST 8'h0A
`define IDP_W_SER_LAST 8'h13
`define IDP_W_MOD_FIRST 8'h1B
`define IDP_W_MOD_LAST 8'h2E
`define IDP_W_MULT_MAX 8'h2F
`define IDP_W_CAPS 8'h31
`define IDP_W_PIO_OLD 8'h33
`define IDP_W_VALID 8'h35
`define IDP_W_CUR_CYL 8'h36
`define IDP_W_CUR_HEAD 8'h37
`define IDP_W_CUR_SPT 8'h38
`define IDP_W_CAP_LO 8'h39
`define IDP_W_CAP_HI 8'h3A
`define IDP_W_MULT_SET 8'h3B
`define IDP_W_LBA_LO 8'h3C
`define IDP_W_LBA_HI 8'h3D
`define IDP_W_MDMA 8'h3F
`define IDP_W_PIO_ADV 8'h40
`define IDP_W_MDMA_MIN 8'h41
`define IDP_W_MDMA_REC 8'h42
`define IDP_W_PIO_MIN 8'h43
`define IDP_W_PIO_IORDY 8'h44
`define IDP_W_SATA_CAPS 8'h4C

`define IDP_CONFIG_DEF 16'h045A
`define IDP_CONFIG_FIXED_BIT 6
`define IDP_CAPS_DEF 16'h0F00
`define IDP_PIO_OLD_DEF 16'h0200
`define IDP_VALID_DEF 16'h0007
`define IDP_MULT_VALID_BIT 8
`define IDP_MDMA_SUP_DEF 8'h07
`define IDP_PIO_ADV_DEF 16'h0003
`define IDP_CYCLE_NS_DEF 16'h0078
`define IDP_SATA_CAPS_DEF 16'h0006
`define IDP_SPACE 8'h20

// Software register port, word addresses of the port
`define IDP_R_GEOM 4'h0
`define IDP_R_TOTAL 4'h1
`define IDP_R_LBA 4'h2
`define IDP_R_MULT 4'h3
`define IDP_R_MDMA 4'h4
`define IDP_R_SER_LEN 4'h5
`define IDP_R_MOD_LEN 4'h6
`define IDP_R_SER_CHR 4'h7
`define IDP_R_MOD_CHR 4'h8
`define IDP_R_CAP 4'h9

`define IDP_SER_CHARS 20
`define IDP_MOD_CHARS 40

`endif

// [shared/identify_param_pkg.sv]
// Types for the identify parameter record block.
// Assumes identify_param_map.svh is on the include path.
`include "identify_param_map.svh"

package identify_param_pkg;

  typedef struct packed {
    logic req;
    logic [7:0] index;
  } word_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } word_rsp_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

endpackage

// [verilog/identify_param_block.sv]
// Parameter record of the identify command: geometry, strings and mode
// words set by software, served one 16-bit word per request.
// Assumes a command engine on the same clock asks for words by index.
`include "identify_param_map.svh"
`timescale 1ns/100ps
`default_nettype none

module identify_param_block #(
  parameter logic [15:0] CYL_DEF = 16'h3FFF,
  parameter logic [15:0] HEAD_DEF = 16'h0010,
  parameter logic [15:0] SPT_DEF = 16'h003F,
  parameter logic [7:0] MULT_MAX_DEF = 8'h01
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Software register port
  input wire identify_param_pkg::reg_req_t i_reg,
  output logic [31:0] o_reg_rdata,
  // Word requests from the command engine
  input wire identify_param_pkg::word_req_t i_word,
  output identify_param_pkg::word_rsp_t o_word
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cyl;
    logic [15:0] head;
    logic [15:0] spt;
    logic [31:0] total;
    logic [31:0] lba;
    logic [7:0] mult_max;
    logic mult_cur;
    logic [2:0] mdma_sel;
    logic [5:0] ser_len;
    logic [5:0] mod_len;
    logic [`IDP_SER_CHARS*8-1:0] ser;
    logic [`IDP_MOD_CHARS*8-1:0] mod;
    logic [31:0] cap;
    logic [31:0] rdata;
    logic rsp_valid;
    logic [15:0] rsp_data;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Serial char c (0 = leftmost char of the field) right-justified in 20 chars
  function automatic logic [7:0] ser_char(input state_t s,
                                          input logic [5:0] c);
    logic [5:0] pad;
    logic [5:0] k;
    pad = 6'(`IDP_SER_CHARS) - s.ser_len;
    k = c - pad;
    if (c < pad) begin
      ser_char = `IDP_SPACE;
    end else begin
      ser_char = s.ser[8*k +: 8];
    end
  endfunction

  // Model char c left-justified in 40 chars
  function automatic logic [7:0] mod_char(input state_t s,
                                          input logic [5:0] c);
    if (c >= s.mod_len) begin
      mod_char = `IDP_SPACE;
    end else begin
      mod_char = s.mod[8*c +: 8];
    end
  endfunction

  // One-hot selected mode, at most one bit set
  function automatic logic [2:0] one_hot3(input logic [1:0] m);
    case (m)
      2'h0: one_hot3 = 3'h1;
      2'h1: one_hot3 = 3'h2;
      2'h2: one_hot3 = 3'h4;
      default: one_hot3 = 3'h0;
    endcase
  endfunction

  // Word assembly
  function automatic logic [15:0] word_at(input state_t s,
                                          input logic [7:0] idx);
    logic [5:0] c;
    logic [15:0] w;
    logic [15:0] cfg;
    w = 16'h0000;
    cfg = `IDP_CONFIG_DEF;
    cfg[`IDP_CONFIG_FIXED_BIT] = 1'b1;
    if (idx >= `IDP_W_SER_FIRST && idx <= `IDP_W_SER_LAST) begin
      c = 6'((idx - `IDP_W_SER_FIRST) * 2);
      // First char sits in the high byte of each word
      w = {ser_char(s, c), ser_char(s, c + 6'h01)};
    end else if (idx >= `IDP_W_MOD_FIRST && idx <= `IDP_W_MOD_LAST) begin
      c = 6'((idx - `IDP_W_MOD_FIRST) * 2);
      w = {mod_char(s, c), mod_char(s, c + 6'h01)};
    end else begin
      case (idx)
        `IDP_W_CONFIG: w = cfg;
        `IDP_W_CYL, `IDP_W_CUR_CYL: w = s.cyl;
        `IDP_W_HEAD, `IDP_W_CUR_HEAD: w = s.head;
        `IDP_W_SPT, `IDP_W_CUR_SPT: w = s.spt;
        `IDP_W_TOT_LO: w = s.total[15:0];
        `IDP_W_TOT_HI: w = s.total[31:16];
        `IDP_W_MULT_MAX: w = {8'h00, s.mult_max};
        `IDP_W_CAPS: w = `IDP_CAPS_DEF;
        `IDP_W_PIO_OLD: w = `IDP_PIO_OLD_DEF;
        `IDP_W_VALID: w = `IDP_VALID_DEF;
        `IDP_W_CAP_LO: w = s.cap[15:0];
        `IDP_W_CAP_HI: w = s.cap[31:16];
        `IDP_W_MULT_SET: begin
          w[`IDP_MULT_VALID_BIT] = 1'b1;
          w[0] = s.mult_cur;
        end
        `IDP_W_LBA_LO: w = s.lba[15:0];
        `IDP_W_LBA_HI: w = s.lba[31:16];
        `IDP_W_MDMA: w = {5'h00, s.mdma_sel, `IDP_MDMA_SUP_DEF};
        `IDP_W_PIO_ADV: w = `IDP_PIO_ADV_DEF;
        // Same figure in 65..68 keeps 66 >= 65 and 67 >= 68
        `IDP_W_MDMA_MIN: w = `IDP_CYCLE_NS_DEF;
        `IDP_W_MDMA_REC: w = `IDP_CYCLE_NS_DEF;
        `IDP_W_PIO_MIN: w = `IDP_CYCLE_NS_DEF;
        `IDP_W_PIO_IORDY: w = `IDP_CYCLE_NS_DEF;
        `IDP_W_SATA_CAPS: w = `IDP_SATA_CAPS_DEF;
        default: w = 16'h0000;
      endcase
    end
    word_at = w;
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [4:0] ci;
    ci = i_reg.wdata[20:16];
    s_d = s_q;
    s_d.rsp_valid = i_word.req;
    if (i_word.req) begin
      s_d.rsp_data = word_at(s_q, i_word.index);
    end
    // Capacity is recomputed from geometry, never written directly
    s_d.cap = 32'(s_q.cyl * s_q.head) * 32'(s_q.spt);
    if (i_reg.wr) begin
      case (i_reg.addr)
        `IDP_R_GEOM: begin
          s_d.cyl = i_reg.wdata[15:0];
          s_d.head = {8'h00, i_reg.wdata[23:16]};
          s_d.spt = {8'h00, i_reg.wdata[31:24]};
        end
        `IDP_R_TOTAL: s_d.total = i_reg.wdata;
        `IDP_R_LBA: s_d.lba = i_reg.wdata;
        `IDP_R_MULT: begin
          s_d.mult_max = i_reg.wdata[7:0];
          // Only 0 or 1 sector per interrupt is reportable
          s_d.mult_cur = (i_reg.wdata[15:8] != 8'h00);
        end
        `IDP_R_MDMA: s_d.mdma_sel = one_hot3(i_reg.wdata[1:0]);
        `IDP_R_SER_LEN: begin
          if (i_reg.wdata[5:0] <= 6'(`IDP_SER_CHARS)) begin
            s_d.ser_len = i_reg.wdata[5:0];
          end
        end
        `IDP_R_MOD_LEN: begin
          if (i_reg.wdata[5:0] <= 6'(`IDP_MOD_CHARS)) begin
            s_d.mod_len = i_reg.wdata[5:0];
          end
        end
        `IDP_R_SER_CHR: begin
          if (ci < 5'(`IDP_SER_CHARS)) begin
            s_d.ser[8*ci +: 8] = i_reg.wdata[7:0];
          end
        end
        `IDP_R_MOD_CHR: begin
          if (i_reg.wdata[21:16] < 6'(`IDP_MOD_CHARS)) begin
            s_d.mod[8*i_reg.wdata[21:16] +: 8] = i_reg.wdata[7:0];
          end
        end
        default: begin
        end
      endcase
    end
    s_d.rdata = 32'h0000_0000;
    if (i_reg.rd) begin
      case (i_reg.addr)
        `IDP_R_GEOM: s_d.rdata = {s_q.spt[7:0], s_q.head[7:0], s_q.cyl};
        `IDP_R_TOTAL: s_d.rdata = s_q.total;
        `IDP_R_LBA: s_d.rdata = s_q.lba;
        `IDP_R_MULT: s_d.rdata = {23'h0, s_q.mult_cur, s_q.mult_max};
        `IDP_R_MDMA: s_d.rdata = {29'h0, s_q.mdma_sel};
        `IDP_R_SER_LEN: s_d.rdata = {26'h0, s_q.ser_len};
        `IDP_R_MOD_LEN: s_d.rdata = {26'h0, s_q.mod_len};
        `IDP_R_CAP: s_d.rdata = s_q.cap;
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
      s_q.cyl <= CYL_DEF;
      s_q.head <= HEAD_DEF;
      s_q.spt <= SPT_DEF;
      s_q.mult_max <= MULT_MAX_DEF;
      s_q.mdma_sel <= 3'h4;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_reg_rdata = s_q.rdata;
  assign o_word.valid = s_q.rsp_valid;
  assign o_word.data = s_q.rsp_data;

endmodule // identify_param_block

`default_nettype wire

// [testbench/identify_param_properties.sv]
// Port checker for the identify parameter record block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module identify_param_properties (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register port
  input wire identify_param_pkg::reg_req_t i_reg,
  input wire logic [31:0] o_reg_rdata,
  // Word port
  input wire identify_param_pkg::word_req_t i_word,
  input wire identify_param_pkg::word_rsp_t o_word
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_word_answer:
    assert property (i_word.req |=> o_word.valid) else $error("no answer");
  a_no_spurious:
    assert property (!i_word.req |=> !o_word.valid) else $error("spurious");
  a_config_word:
    assert property (i_word.req && i_word.index == 8'h00 |=>
      o_word.data == 16'h045A && o_word.data[6]) else $error("word 0");
  a_caps_bits:
    assert property (i_word.req && i_word.index == 8'h31 |=>
      o_word.data[13:8] == 6'h0F) else $error("word 49");
  a_pio_legacy:
    assert property (i_word.req && i_word.index == 8'h33 |=>
      o_word.data[15:8] == 8'h02) else $error("word 51");
  a_valid_flags:
    assert property (i_word.req && i_word.index == 8'h35 |=>
      o_word.data[2:0] == 3'h7) else $error("word 53");
  a_mult_layout:
    assert property (i_word.req && i_word.index == 8'h3B |=>
      o_word.data[15:8] == 8'h01 && o_word.data[7:1] == 7'h00)
      else $error("word 59");
  a_mdma_onehot:
    assert property (i_word.req && i_word.index == 8'h3F |=>
      o_word.data[15:11] == 5'h00 && $onehot0(o_word.data[10:8]) &&
      o_word.data[7:0] == 8'h07) else $error("word 63");
  a_sata_caps:
    assert property (i_word.req && i_word.index == 8'h4C |=>
      o_word.data[2:0] == 3'h6) else $error("word 76");
endmodule // identify_param_properties
bind identify_param_block identify_param_properties
  identify_param_properties_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_reg(i_reg), .o_reg_rdata(o_reg_rdata), .i_word(i_word),
  .o_word(o_word));
`default_nettype wire

// [testbench/identify_host_model.sv]
// Host side model: asks for the whole record, one word a cycle.
// Assumes the bench pulses i_start while o_busy is low.
`timescale 1ns/100ps
`default_nettype none
module identify_host_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Bench control
  input wire logic i_start,
  output logic o_busy,
  // Word requests
  output identify_param_pkg::word_req_t o_word
);
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_word <= '0;
      o_busy <= 1'b0;
    end else if (i_start && !o_busy) begin
      o_busy <= 1'b1;
      o_word <= '{req: 1'b1, index: 8'h00};
    end else if (o_busy && o_word.index == 8'hFF) begin
      o_busy <= 1'b0;
      o_word.req <= 1'b0;
      // Idle index differs from the last one so stale reuse shows
      o_word.index <= ~o_word.index;
    end else if (o_busy) begin
      o_word.index <= o_word.index + 8'h01;
    end
  end
endmodule // identify_host_model
`default_nettype wire

// [testbench/identify_param_block_bench.sv]
// Bench for the identify parameter record block.
// Assumes the host model on the word port and 125 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module identify_param_block_bench;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic start = 1'b0;
  logic busy;
  logic [7:0] idx_q;
  logic [31:0] rdata;
  logic [15:0] rec [256];
  identify_param_pkg::reg_req_t reg_q = '0;
  identify_param_pkg::word_req_t word;
  identify_param_pkg::word_rsp_t rsp;
  int error_cnt = 0;
  int checks = 0;
  logic [23:0] rows [30] = '{24'h00045A,
    24'h013FFF, 24'h030010, 24'h06003F,
    24'h070000, 24'h080000, 24'h0A2020, 24'h132020,
    24'h1B2020, 24'h2E2020, 24'h2F0001,
    24'h310F00, 24'h330200, 24'h350007, 24'h39FC10,
    24'h3A00FB, 24'h3B0100, 24'h3C0000, 24'h3F0407,
    24'h400003, 24'h410078, 24'h420078, 24'h430078,
    24'h440078, 24'h4C0006, 24'h020000, 24'h170000,
    24'h450000, 24'h4D0000, 24'hFF0000};
  always #4 i_clk = ~i_clk;
  identify_param_block identify_param_block_i (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_reg(reg_q), .o_reg_rdata(rdata),
    .i_word(word), .o_word(rsp));
  identify_host_model identify_host_model_i (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_start(start), .o_busy(busy), .o_word(word));
  always @(posedge i_clk) begin
    idx_q <= word.index;
    if (rsp.valid === 1'b1) rec[idx_q] <= rsp.data;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_q <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    reg_q.wr <= 1'b0;
    // Gap edge so a following write never reassigns the strobe at once
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    reg_q <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge i_clk);
    reg_q.rd <= 1'b0;
    @(negedge i_clk);
    chk(rdata, exp);
    @(posedge i_clk);
  endtask
  task automatic stream();
    int n;
    n = 0;
    start <= 1'b1;
    @(posedge i_clk);
    start <= 1'b0;
    @(posedge i_clk);
    while (busy === 1'b1 && n < 300) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 300) error_cnt++;
    repeat (2) @(posedge i_clk);
  endtask
  task automatic stop_test();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    chk(rsp.valid, 1'b0);
    chk(rdata, 32'h0);
    @(posedge i_clk);
    stream();
    foreach (rows[k]) chk(rec[rows[k][23:16]], rows[k][15:0]);
    wr(4'h0, 32'h2004_1000);
    wr(4'h1, 32'h0012_3456);
    wr(4'h2, 32'h0ABC_DEF0);
    wr(4'h3, 32'h0000_0101);
    wr(4'h5, 32'h0000_0002);
    wr(4'h5, 32'h0000_0015);
    wr(4'h7, 32'h0000_0041);
    wr(4'h7, 32'h0001_0042);
    wr(4'h6, 32'h0000_0001);
    wr(4'h8, 32'h0000_004D);
    @(posedge i_clk);
    rd(4'h9, 32'h0008_0000);
    rd(4'hF, 32'h0);
    rd(4'h0, 32'h2004_1000);
    rd(4'h1, 32'h0012_3456);
    rd(4'h2, 32'h0ABC_DEF0);
    rd(4'h3, 32'h0000_0101);
    rd(4'h4, 32'h0000_0004);
    rd(4'h5, 32'h0000_0002);
    wr(4'h6, 32'h0000_0029);
    rd(4'h6, 32'h0000_0001);
    stream();
    chk({rec[6], rec[3], rec[1]}, 48'h0020_0004_1000);
    chk({rec[56], rec[55], rec[54]}, 48'h0020_0004_1000);
    chk({rec[58], rec[57]}, 32'h0008_0000);
    chk({rec[8], rec[7]}, 32'h0012_3456);
    chk({rec[61], rec[60]}, 32'h0ABC_DEF0);
    chk({rec[18], rec[19]}, 32'h2020_4142);
    chk({rec[27], rec[28]}, 32'h4D20_2020);
    chk({rec[47], rec[59]}, 32'h0001_0101);
    for (int m = 0; m < 4; m++) begin
      wr(4'h4, 32'(m));
      stream();
      chk(rec[63], {(m == 3) ? 8'h00 : 8'h01 << m, 8'h07});
    end
    // Reset in mid-run must bring every setting back to its default
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(4'h0, 32'h3F10_3FFF);
    rd(4'h4, 32'h0000_0004);
    stream();
    chk({rec[58], rec[57]}, 32'h00FB_FC10);
    chk({rec[19], rec[59]}, 32'h2020_0100);
    chk({rec[27], rec[63]}, 32'h2020_0407);
    stop_test();
  end
endmodule // identify_param_block_bench
`default_nettype wire
